// ---- core/pte_pkg.sv ----
// pte_pkg: constants and carrier types for the pulse train engine.
// assumes a single hclk domain and a 32-bit AHB-Lite slave port.
package pte_pkg;
	localparam int         NGEN      = 2;
	localparam int         GEN_BASE  = 2;
	// register byte offsets
	localparam logic [7:0] A_RUN     = 8'h00;
	localparam logic [7:0] A_START   = 8'h04;
	localparam logic [7:0] A_STOP    = 8'h08;
	localparam logic [7:0] A_CFG     = 8'h0C;
	localparam logic [7:0] A_DONE    = 8'h10;
	localparam logic [7:0] A_PIN     = 8'h14;
	localparam logic [7:0] A_CTRL0   = 8'h20;
	localparam logic [7:0] A_PAT0    = 8'h24;
	localparam logic [7:0] A_LOOP0   = 8'h28;
	localparam logic [7:0] A_STRIDE  = 8'h10;
	localparam int         ADDR_W    = 8;
	// control field layout
	localparam int         C_MODE    = 0;
	localparam int         C_LEN     = 1;
	localparam int         C_DIV     = 8;
	localparam int         C_IDLE    = 12;
	localparam int         C_CHAIN   = 16;
	localparam logic [4:0] LEN_MIN   = 5'h01;
	localparam logic [7:0] CNT_ONE   = 8'h01;
	localparam logic [7:0] DIV_UNIT  = 8'h02;
	localparam logic [15:0] LOOP_INF = 16'h0000;
	localparam logic [15:0] LOOP_ONE = 16'h0001;
	localparam logic [1:0] HT_NSEQ   = 2'h2;

	typedef struct packed {
		logic [NGEN-1:0] chain;
		logic            idle;
		logic [2:0]      div;
		logic [4:0]      len;
		logic            pattern;
	} pte_ctrl_t;

	typedef struct packed {
		logic        run;
		logic [4:0]  bitpos;
		logic [15:0] left;
		logic [31:0] pat;
		logic [15:0] loops;
		pte_ctrl_t   ctrl;
		logic        out;
	} pte_gen_t;

	typedef struct packed {
		pte_gen_t [NGEN-1:0] gen;
		logic [7:0]          mcnt;
		logic [NGEN-1:0]     done;
		logic                clk_sel;
		logic [NGEN-1:0]     pin_sel;
		logic [NGEN-1:0]     pin;
		logic                ap_wr;
		logic                ap_rd;
		logic [ADDR_W-1:0]   ap_addr;
		logic [31:0]         rdata;
	} pte_state_t;

	localparam pte_state_t S_RST = '0;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
	} pte_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} pte_ahb_rsp_t;
endpackage

// ---- core/pte_top.sv ----
// pte_top: two pulse train generators behind an AHB-Lite register slave.
// assumes hclk-synchronous inputs; alt_tick is a one-cycle enable from
// an independent source, already in the hclk domain.
// ports
//   ce        high runs; low freezes all state and stalls the bus
//   alt_tick  module tick, used when cfg bit 0 is set
//   hready    the bus's hready, looped back from our hreadyout
//   gpio_out  ordinary gpio levels for the two pins
//   pin_out   registered pin levels, gpio or generator
// reset: hresetn clears every register; pins read low while held
//
// register map, byte offsets, one word each
//   0x00 run      read only, bit g set while generator g runs
//   0x04 start    write ones to start; several ones start a group in step
//   0x08 stop     write ones to stop; output falls to idle, no done flag
//   0x0C cfg      bit 0 picks the module clock: 0 hclk, 1 alt_tick
//   0x10 done     bit g set on completion, write one to clear
//   0x14 pin      bit g hands pin g to its generator
//   0x20 + 0x10*g per-generator block of generator g
//     +0 ctrl     bit 0 pattern, 5:1 last bit index, 10:8 divider,
//                 bit 12 idle level, 17:16 chain mask
//     +4 pattern  bits sent lsb first
//     +8 loops    15:0 repeat count; zero runs forever, one is single-shot
//   unmapped offsets read as zero and ignore writes
//   index 0 is instance two, index 1 is instance three
//
// bus timing
//   zero wait states while ce is high; hreadyout simply follows ce
//   write c0: nonseq, address and hwrite on the bus; the edge takes it
//   write c1: idle, hwdata on the bus; the edge stores the word
//   read c0: nonseq with hwrite low; the edge loads hrdata
//   read c1: hrdata stands; the master takes it at the closing edge
//   hazard: a read right behind a write to the same word sees the old value
//   hrdata holds until the next read address phase is taken
//
// generator timing
//   start edge: run sets and bit 0 appears on the pin at once
//   bits advance on module ticks when the low div+1 bits of the shared
//     count are all ones, so the first bit may come out short
//   the shared count keeps a group started together on common boundaries
//   after the last bit of the last loop the output drops to idle
//   chained generators start at the edge where the finisher stops
//   square mode ignores the loop count and runs until stopped
//   example, three bit pattern, one loop:
//     start edge: pin shows bit 0
//     next two boundaries: bits 1 and 2
//     third boundary: idle level, run clear, done set
//
// limitations
//   start and stop in one write: stop wins
//   a start while running restarts at bit 0
//   alt_tick must already be a one-cycle pulse in the hclk domain
//   only haddr bits 7:0 decode; higher bits alias
//   hsize is ignored, every access is a whole word
//   divider codes above 6 all give the slowest rate of the 8-bit count
//   a pin not handed to a generator shows gpio one cycle late
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pte_top (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  ce,
	input  wire logic                  alt_tick,
	input  wire pte_pkg::pte_ahb_req_t ahb_req,
	input  wire logic                  hready,
	output pte_pkg::pte_ahb_rsp_t      ahb_rsp,
	input  wire logic [1:0]            gpio_out,
	output logic [1:0]                 pin_out
);
	import pte_pkg::*;

	// whole block state, registered in one place
	pte_state_t      s_r;
	pte_state_t      s_nxt;
	// per-cycle strobes decoded from state and bus
	logic            tick_m;
	logic [NGEN-1:0] fin;
	logic [NGEN-1:0] go;
	logic [NGEN-1:0] stop;
	logic [NGEN-1:0] clr;
	logic [31:0]     rd_val;
	logic [31:0]     wd;

	// bit tick when the low div+1 bits of the shared count are all ones
	function automatic logic div_hit(input logic [7:0] cnt, input logic [2:0] d);
		logic [7:0] mask;
		mask = (DIV_UNIT << d) - CNT_ONE;
		return &(cnt | ~mask);
	endfunction

	// register decode for the per-generator block
	function automatic logic gen_hit(input logic [ADDR_W-1:0] a, input logic [7:0] base, input int g);
		logic [7:0] off;
		off = 8'(g) * A_STRIDE;
		return a == (base + off);
	endfunction

	// last bit index; lengths under two are raised to two
	function automatic logic [4:0] last_bit(input logic [4:0] len);
		return (len < LEN_MIN) ? LEN_MIN : len;
	endfunction

	// unpack a control word into its fields
	function automatic pte_ctrl_t ctrl_of(input logic [31:0] d);
		pte_ctrl_t c;
		c.pattern = d[C_MODE];
		c.len     = d[C_LEN +: 5];
		c.div     = d[C_DIV +: 3];
		c.idle    = d[C_IDLE];
		c.chain   = d[C_CHAIN +: NGEN];
		return c;
	endfunction

	// pack control fields back into a read word, spare bits zero
	function automatic logic [31:0] ctrl_rd(input pte_ctrl_t c);
		logic [31:0] d;
		d = '0;
		d[C_MODE]        = c.pattern;
		d[C_LEN +: 5]    = c.len;
		d[C_DIV +: 3]    = c.div;
		d[C_IDLE]        = c.idle;
		d[C_CHAIN +: NGEN] = c.chain;
		return d;
	endfunction

	// bus answers at once while ce is high; no error responses exist
	assign ahb_rsp.hrdata    = s_r.rdata;
	assign ahb_rsp.hreadyout = ce;
	assign ahb_rsp.hresp     = 1'b0;
	assign pin_out           = s_r.pin;
	assign wd                = ahb_req.hwdata;

	// read mux over current state
	always_comb begin
		rd_val = '0;
		unique case (ahb_req.haddr[ADDR_W-1:0])
			A_RUN:   begin
				for (int g = 0; g < NGEN; g++) begin
					rd_val[g] = s_r.gen[g].run;
				end
			end
			A_CFG:   rd_val[0] = s_r.clk_sel;
			A_DONE:  rd_val[NGEN-1:0] = s_r.done;
			A_PIN:   rd_val[NGEN-1:0] = s_r.pin_sel;
			default: begin
				for (int g = 0; g < NGEN; g++) begin
					if (gen_hit(ahb_req.haddr[ADDR_W-1:0], A_CTRL0, g)) begin
						rd_val = ctrl_rd(s_r.gen[g].ctrl);
					end
					if (gen_hit(ahb_req.haddr[ADDR_W-1:0], A_PAT0, g)) begin
						rd_val = s_r.gen[g].pat;
					end
					if (gen_hit(ahb_req.haddr[ADDR_W-1:0], A_LOOP0, g)) begin
						rd_val[15:0] = s_r.gen[g].loops;
					end
				end
			end
		endcase
	end

	// next-state: generators, chaining, then bus writes, then starts
	always_comb begin
		s_nxt = s_r;
		fin   = '0;
		go    = '0;
		stop  = '0;
		clr   = '0;
		tick_m = s_r.clk_sel ? alt_tick : 1'b1;
		if (tick_m) begin
			s_nxt.mcnt = s_r.mcnt + CNT_ONE;
		end
		// two generators
		// index 0 is instance two, index 1 instance three
		for (int g = 0; g < NGEN; g++) begin
			if (s_r.gen[g].run && tick_m && div_hit(s_r.mcnt, s_r.gen[g].ctrl.div)) begin
				if (!s_r.gen[g].ctrl.pattern) begin
					s_nxt.gen[g].out = ~s_r.gen[g].out;
				end else if (s_r.gen[g].bitpos == last_bit(s_r.gen[g].ctrl.len)) begin
					s_nxt.gen[g].bitpos = '0;
					s_nxt.gen[g].out    = s_r.gen[g].pat[0];
					if (s_r.gen[g].loops != LOOP_INF) begin
						// single-shot is a count of one
						if (s_r.gen[g].left == LOOP_ONE) begin
							fin[g] = 1'b1;
						end
						s_nxt.gen[g].left = s_r.gen[g].left - LOOP_ONE;
					end
				end else begin
					s_nxt.gen[g].bitpos = s_r.gen[g].bitpos + CNT_ONE[4:0];
					s_nxt.gen[g].out    = s_r.gen[g].pat[s_r.gen[g].bitpos + CNT_ONE[4:0]];
				end
			end
			// stop to idle and flag done
			if (fin[g]) begin
				s_nxt.gen[g].run = 1'b0;
				s_nxt.gen[g].out = s_r.gen[g].ctrl.idle;
			end
		end
		for (int g = 0; g < NGEN; g++) begin
			if (fin[g]) begin
				go = go | s_r.gen[g].ctrl.chain;
			end
		end
		// data-phase writes
		// software writes land after hardware updates, so they win, except a done clear, which loses to a completion in the same cycle
		if (s_r.ap_wr) begin
			unique case (s_r.ap_addr)
				A_START: go = go | wd[NGEN-1:0];
				A_STOP:  stop = wd[NGEN-1:0];
				A_CFG:   s_nxt.clk_sel = wd[0];
				A_DONE:  clr = wd[NGEN-1:0];
				A_PIN:   s_nxt.pin_sel = wd[NGEN-1:0];
				default: begin
					for (int g = 0; g < NGEN; g++) begin
						if (gen_hit(s_r.ap_addr, A_CTRL0, g)) begin
							s_nxt.gen[g].ctrl = ctrl_of(wd);
						end
						if (gen_hit(s_r.ap_addr, A_PAT0, g)) begin
							s_nxt.gen[g].pat = wd;
						end
						if (gen_hit(s_r.ap_addr, A_LOOP0, g)) begin
							s_nxt.gen[g].loops = wd[15:0];
						end
					end
				end
			endcase
		end
		for (int g = 0; g < NGEN; g++) begin
			// manual stop goes idle without done
			if (stop[g]) begin
				s_nxt.gen[g].run = 1'b0;
				s_nxt.gen[g].out = s_nxt.gen[g].ctrl.idle;
			end
			// starts land on a shared count phase, so groups align
			if (go[g] && !stop[g]) begin
				s_nxt.gen[g].run    = 1'b1;
				s_nxt.gen[g].bitpos = '0;
				s_nxt.gen[g].left   = s_nxt.gen[g].loops;
				s_nxt.gen[g].out    = s_nxt.gen[g].ctrl.pattern ? s_nxt.gen[g].pat[0] : 1'b1;
			end
			s_nxt.pin[g] = s_nxt.pin_sel[g] ? s_nxt.gen[g].out : gpio_out[g];
		end
		s_nxt.done = (s_r.done & ~clr) | fin;
		// address phase capture
		// hready low clears ap_wr and ap_rd; ap_addr and rdata keep their old values
		s_nxt.ap_wr = 1'b0;
		s_nxt.ap_rd = 1'b0;
		if (hready) begin
			s_nxt.ap_wr   = ahb_req.hsel && ahb_req.htrans == HT_NSEQ && ahb_req.hwrite;
			s_nxt.ap_rd   = ahb_req.hsel && ahb_req.htrans == HT_NSEQ && !ahb_req.hwrite;
			s_nxt.ap_addr = ahb_req.haddr[ADDR_W-1:0];
			if (s_nxt.ap_rd) begin
				s_nxt.rdata = rd_val;
			end
		end
	end

	// single state register; ce low freezes everything
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= S_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end
endmodule // pte_top

// ---- sim/pte_top_properties.sv ----
// pte_top_properties: port-level checks of pte_top, bound to the design.
// assumes an AHB-Lite master doing single word transfers.
`timescale 1ns/1ps
module pte_top_properties
	import pte_pkg::*;
(
	input wire logic                  hclk,
	input wire logic                  hresetn,
	input wire logic                  ce,
	input wire logic                  alt_tick,
	input wire pte_pkg::pte_ahb_req_t ahb_req,
	input wire logic                  hready,
	input wire pte_pkg::pte_ahb_rsp_t ahb_rsp,
	input wire logic [1:0]            gpio_out,
	input wire logic [1:0]            pin_out
);
	logic       tk;
	logic       rt;
	logic       wp_r;
	logic       idle_r;
	logic [7:0] wa_r;
	logic [1:0] sel_r;
	// transfer taken in an address phase
	assign tk = hready & ce & ahb_req.hsel & (ahb_req.htrans == HT_NSEQ);
	assign rt = tk & ~ahb_req.hwrite;
	// snoop writes: pin selection and idle level of the first generator
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wp_r, wa_r, sel_r, idle_r} <= '0;
		end else if (hready & ce) begin
			wp_r <= tk & ahb_req.hwrite;
			wa_r <= ahb_req.haddr[7:0];
			if (wp_r && wa_r == A_PIN) sel_r <= ahb_req.hwdata[1:0];
			if (wp_r && wa_r == A_CTRL0) idle_r <= ahb_req.hwdata[C_IDLE];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_rdy; ahb_rsp.hreadyout == ce; endproperty
	a_rdy: assert property (p_rdy) else $error("hreadyout not ce");
	property p_gpio; (sel_r | $past(sel_r)) == 2'h0 && $past(ce) && $past(hresetn) |-> pin_out == $past(gpio_out);
	endproperty
	a_gpio: assert property (p_gpio) else $error("pin not gpio");
	property p_frz; !ce |=> $stable(pin_out); endproperty
	a_frz: assert property (p_frz) else $error("pin moved while frozen");
	property p_hold; !rt |=> $stable(ahb_rsp.hrdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap; rt && ahb_req.haddr[7:0] >= 8'h40 |=> ahb_rsp.hrdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_run; rt && ahb_req.haddr[7:0] == A_RUN |=> ahb_rsp.hrdata[31:2] == 30'h0; endproperty
	a_run: assert property (p_run) else $error("run bits beyond two");
	property p_cfg; rt && ahb_req.haddr[7:0] == A_CFG |=> ahb_rsp.hrdata[31:1] == 31'h0; endproperty
	a_cfg: assert property (p_cfg) else $error("cfg spare bits set");
	property p_stop; wp_r && hready && ce && wa_r == A_STOP && ahb_req.hwdata[0] && sel_r[0] |=> pin_out[0] == idle_r;
	endproperty
	a_stop: assert property (p_stop) else $error("stopped pin not idle");
endmodule // pte_top_properties
bind pte_top pte_top_properties chk_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .alt_tick(alt_tick),
	.ahb_req(ahb_req), .hready(hready), .ahb_rsp(ahb_rsp), .gpio_out(gpio_out), .pin_out(pin_out));

// ---- sim/pte_pin_model.sv ----
// pte_pin_model: gpio logic and board behind the two pins.
// assumes hclk; gpio bit 0 changes every cycle, bit 1 holds while pin 0 was seen high.
`timescale 1ns/1ps
module pte_pin_model (
	input  wire logic       hclk,
	input  wire logic [1:0] pin_out,
	output logic      [1:0] gpio_out
);
	logic [1:0] seen_r;
	initial gpio_out = 2'h1;
	// toggling levels, a pin stuck on old gpio data mismatches
	always @(posedge hclk) gpio_out <= ~gpio_out ^ {seen_r[0], 1'b0};
	// board samples the pins; the sampled pin 0 feeds back into gpio bit 1
	always @(posedge hclk) seen_r <= pin_out;
endmodule // pte_pin_model

// ---- sim/test_pulse_train_engine.sv ----
// test_pulse_train_engine: random and corner tests of pte_top.
// assumes pte_pin_model on the pins and a 10 MHz hclk.
`timescale 1ns/1ps
module test_pulse_train_engine;
	import pte_pkg::*;
	logic hclk = 0, hresetn = 0, ce = 1, tick = 0, idl;
	bit cerand = 0, tickon = 1, q[$];
	pte_ahb_req_t req = '0;
	pte_ahb_rsp_t rsp;
	logic [1:0] gpio, pin;
	logic [7:0] b, ra [6] = '{A_RUN, A_CFG, A_DONE, A_PIN, 8'h18, 8'h40};
	logic [31:0] d, pat;
	int miscompares = 0, num_checks = 0, s, L, n, p, g;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value t=%0t got=%h exp=%h", $time, a, e); end end
	initial forever #50 hclk = ~hclk;
	pte_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .alt_tick(tick), .ahb_req(req),
		.hready(rsp.hreadyout), .ahb_rsp(rsp), .gpio_out(gpio), .pin_out(pin));
	pte_pin_model pm_u (.hclk(hclk), .pin_out(pin), .gpio_out(gpio));
	// random stalls and module ticks
	always @(posedge hclk) begin
		ce <= !cerand || $urandom_range(3) != 0;
		tick <= tickon && $urandom_range(1);
	end
	// one single transfer, waits out stalls
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		req <= '{1'b1, {24'h0, a}, HT_NSEQ, w, 3'h2, req.hwdata};
		do @(posedge hclk); while (!rsp.hreadyout);
		req.htrans <= 2'h0;
		req.hwdata <= wd;
		do @(posedge hclk); while (!rsp.hreadyout);
		rd = rsp.hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		bus(1'b1, a, v, x);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, d);
		`CHK(d, e)
		`CHK(rsp.hresp, 1'b0)
	endtask
	task automatic results;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h4BAF));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (ra[i]) rc(ra[i], 32'h0);
		// registers under random stalls
		cerand = 1;
		pat = $urandom;
		wr(A_PAT0, 32'hA5C3_0F96);
		wr(A_PAT0 + A_STRIDE, pat);
		wr(8'h40, 32'hFFFF_FFFF);
		rc(A_PAT0, 32'hA5C3_0F96);
		rc(A_PAT0 + A_STRIDE, pat);
		rc(8'h40, 32'h0);
		cerand = 0;
		wr(A_PIN, 32'h3);
		// patterns: lengths 2, 32 and random; three dividers; 1..3 loops
		for (int t = 0; t < 6; t++) begin
			g = t % 2;
			b = 8'(16 * g);
			L = (t == 0) ? 2 : (t == 1) ? 32 : $urandom_range(32, 2);
			p = 2 << (t % 3);
			n = 1 + (t / 2);
			pat = $urandom;
			pat[1] = ~pat[0];
			idl = ~pat[L - 1];
			wr(A_CTRL0 + b, 32'(idl) << C_IDLE | 32'(t % 3) << C_DIV | 32'(L - 1) << C_LEN | 32'h1);
			wr(A_PAT0 + b, pat);
			wr(A_LOOP0 + b, 32'(n));
			wr(A_START, 32'(1 << g));
			q.delete();
			repeat ((n * L + 2) * p) begin
				@(posedge hclk);
				q.push_back(pin[g]);
			end
			s = 1;
			while (s < p && q[s] == q[0]) s++;
			`CHK(q[0], pat[0])
			for (int k = 1; k <= n * L; k++) `CHK(q[s + (k - 1) * p + p / 2], (k < n * L) ? pat[k % L] : idl)
			rc(A_RUN, 32'h0);
			rc(A_DONE, 32'(1 << g));
			wr(A_DONE, 32'h3);
		end
		// square wave on the first generator, divider code 1: half period of 4
		wr(A_CTRL0, 32'h0000_0100);
		wr(A_START, 32'h1);
		q.delete();
		repeat (24) begin
			@(posedge hclk);
			q.push_back(pin[0]);
		end
		s = 1;
		while (s < 4 && q[s] == q[0]) s++;
		`CHK(q[0], 1'b1)
		for (int k = 0; k < 4; k++) `CHK(q[s + k * 4 + 2], 1'(k % 2))
		wr(A_STOP, 32'h1);
		// group start, then chaining from the first generator
		wr(A_CTRL0, 32'h0002_0103);
		wr(A_CTRL0 + A_STRIDE, 32'h0000_0103);
		wr(A_PAT0, 32'h1);
		wr(A_PAT0 + A_STRIDE, 32'h1);
		wr(A_LOOP0, 32'h1);
		wr(A_LOOP0 + A_STRIDE, 32'h0);
		wr(A_START, 32'h3);
		repeat (5) begin
			@(posedge hclk);
			`CHK(pin[1], pin[0])
		end
		repeat (10) @(posedge hclk);
		wr(A_STOP, 32'h2);
		rc(A_RUN, 32'h0);
		rc(A_DONE, 32'h1);
		wr(A_START, 32'h1);
		repeat (20) @(posedge hclk);
		rc(A_RUN, 32'h2);
		wr(A_STOP, 32'h3);
		// module clock from the independent tick
		tickon = 0;
		wr(A_CFG, 32'h1);
		wr(A_START, 32'h1);
		repeat (30) @(posedge hclk);
		rc(A_RUN, 32'h1);
		tickon = 1;
		repeat (200) @(posedge hclk);
		rc(A_RUN, 32'h2);
		// reset in mid-run clears everything again
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		foreach (ra[i]) rc(ra[i], 32'h0);
		results();
	end
	// watchdog, far beyond the expected run
	initial begin
		#4_000_000;
		miscompares++;
		results();
	end
endmodule // test_pulse_train_engine
